// [bench/mac_cfg_vector_chk.sv]
// Assertions on vectors, PFC hold and RS fault selection
`default_nettype none
`include "mac_cfg_regs.vh"
module mac_cfg_vector_chk #(
    parameter int PRIORITIES = 8,
    parameter int QUANTA_W   = 16
) (
    input wire logic                           sys_clk,
    input wire logic                           nrst,
    input wire logic                           txFrameActive,
    input wire logic                           localFault,
    input wire logic                           remoteFault,
    input wire logic                           linkInterrupt,
    input wire logic                           rxPfcValid,
    input wire logic                           rxPfcGood,
    input wire logic [PRIORITIES-1:0]          rxPfcClassEnable,
    input wire logic [PRIORITIES*QUANTA_W-1:0] rxPfcQuanta,
    input wire logic [79:0]                    mac_tx_configuration_vector,
    input wire logic [95:0]                    mac_rx_configuration_vector,
    input wire logic [PRIORITIES-1:0]          rxPriorityHoldOutput,
    input wire logic                           rxPfcMarkBad,
    input wire logic [1:0]                     rsTxSelect,
    input wire logic                           txResetOut
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0]  upCount;
    logic        live;
    logic        load0;
    logic [15:0] q0;
    logic [79:0] txv;
    logic [95:0] rxv;
    assign txv = mac_tx_configuration_vector;
    assign rxv = mac_rx_configuration_vector;
    assign live = upCount == 2'h3;
    assign q0 = rxPfcQuanta[15:0];
    assign load0 = rxPfcValid && rxPfcGood && rxPfcClassEnable[0]
        && rxv[80] && rxv[88];
    // Wait out the reset synchroniser
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst)
            upCount <= 2'h0;
        else if (!live)
            upCount <= upCount + 2'h1;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst || !live);
    remote_on_local_a: assert property (
        !rxv[10] && (localFault || linkInterrupt)
        |=> rsTxSelect == `RS_SEND_REMOTE) else $error("remote fault not sent");
    idle_on_remote_a: assert property (
        !rxv[10] && remoteFault && !localFault && !linkInterrupt
        |=> rsTxSelect == `RS_SEND_IDLE) else $error("idle not sent");
    inhibit_passes_a: assert property (
        rxv[10] |=> rsTxSelect == `RS_PASS_DATA) else $error("data not passed");
    pfc_mark_a: assert property (
        rxPfcMarkBad == $past(rxPfcValid && rxv[80])) else $error("mark wrong");
    hold_start_a: assert property (
        load0 && q0 != 16'h0 |=> rxPriorityHoldOutput[0])
        else $error("hold not started");
    hold_length_a: assert property (
        load0 && q0 == 16'h1 |=> rxPriorityHoldOutput[0] [*6]
        ##1 !rxPriorityHoldOutput[0]) else $error("hold length wrong");
    hold_cancel_a: assert property (
        load0 && q0 == 16'h0 |=> !rxPriorityHoldOutput[0])
        else $error("hold not cancelled");
    frame_hold_a: assert property (
        txFrameActive |=> $stable({txv[31:6], txv[4:1]}))
        else $error("tx fields changed in frame");
    tx_reset_a: assert property (
        txv[0] |-> ##[0:2] txResetOut) else $error("tx reset not applied");
endmodule // mac_cfg_vector_chk

bind mac_config_vector_control mac_cfg_vector_chk #(
    .PRIORITIES(PRIORITIES),
    .QUANTA_W(QUANTA_W)
) u_mac_cfg_vector_chk (
    .sys_clk, .nrst, .txFrameActive, .localFault, .remoteFault,
    .linkInterrupt, .rxPfcValid, .rxPfcGood, .rxPfcClassEnable, .rxPfcQuanta,
    .mac_tx_configuration_vector, .mac_rx_configuration_vector,
    .rxPriorityHoldOutput, .rxPfcMarkBad, .rsTxSelect, .txResetOut
);
`default_nettype wire

// [bench/mac_config_vector_control_bench.sv]
// Self-checking bench for the MAC configuration vector block
`default_nettype none
`include "mac_cfg_regs.vh"
module mac_config_vector_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic         sys_clk = 1'h0, nrst = 1'h0;
    logic [7:0]   s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0]  s_axi_wdata = 32'h0, s_axi_rdata, rd, d, e;
    logic [3:0]   s_axi_wstrb = 4'hF;
    logic         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic         s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic         s_axi_rready = 1'h0, localFault = 1'h0;
    logic         remoteFault = 1'h0, linkInterrupt = 1'h0;
    logic         s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic         s_axi_arready, s_axi_rvalid, rxPfcMarkBad;
    logic         txFrameActive, rxFrameActive, rxPfcValid, rxPfcGood;
    logic         txResetOut, rxResetOut;
    logic [1:0]   s_axi_bresp, s_axi_rresp, rsTxSelect, rsp;
    logic [7:0]   rxPfcClassEnable, rxPriorityHoldOutput;
    logic [127:0] rxPfcQuanta;
    logic [79:0]  txv;
    logic [95:0]  rxv;
    logic [31:0]  corner [4] = '{32'h408, 32'h500, 32'h700, 32'h7FFF4402};
    int           errors = 0, check_count = 0;
    always #5 sys_clk = ~sys_clk;
    mac_config_vector_control u_mac_config_vector_control (
        .sys_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .txFrameActive, .rxFrameActive,
        .localFault, .remoteFault, .linkInterrupt, .rxPfcValid, .rxPfcGood,
        .rxPfcClassEnable, .rxPfcQuanta, .mac_tx_configuration_vector(txv),
        .mac_rx_configuration_vector(rxv), .rxPriorityHoldOutput,
        .rxPfcMarkBad, .rsTxSelect, .txResetOut, .rxResetOut);
    mac_side_model u_mac_side_model (.sys_clk, .txFrameActive,
        .rxFrameActive, .rxPfcValid, .rxPfcGood, .rxPfcClassEnable,
        .rxPfcQuanta);
    task automatic chk(input string nm, input logic [31:0] x, g);
        check_count++;
        if (g !== x) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_awvalid && !s_axi_awready
                   || s_axi_wvalid && !s_axi_wready);
        while (!s_axi_bvalid) @(posedge sys_clk);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task automatic pf(input logic [7:0] c, input logic [15:0] q,
                      input logic g);
        u_mac_side_model.pfc_frame(c, q, g);
        #1;
    endtask
    function automatic logic [31:0] tx_eff(input logic [31:0] v);
        logic [31:0] r;
        r = v & `CFG_WRITE_MASK;
        if (r[9]) r[8] = 1'h0;
        if (!r[9] && r[3] || r[8]) r[10] = 1'h0;
        return r;
    endfunction
    function automatic logic [31:0] rs_sel(input logic [3:0] f);
        if (f[3]) return 32'(`RS_PASS_DATA);
        if (f[0] || f[2]) return 32'(`RS_SEND_REMOTE);
        return f[1] ? 32'(`RS_SEND_IDLE) : 32'(`RS_PASS_DATA);
    endfunction
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'h5619));
        repeat (3) @(posedge sys_clk);
        nrst <= 1'h1;
        repeat (4) @(posedge sys_clk);
        for (int a = 0; a < 8; a++) begin
            rd_reg(8'(a * 4));
            chk("reset value", 32'h0, rd);
        end
        rd_reg(8'h40);
        chk("unmapped rresp", 32'(`RESP_SLVERR), 32'(rsp));
        wr(8'h40, 32'hFFFFFFFF);
        chk("unmapped bresp", 32'(`RESP_SLVERR), 32'(rsp));
        for (int i = 0; i < 4; i++) begin
            d = $urandom;
            e = $urandom & `PAUSE_HI_MASK;
            wr(`ADDR_TX_PAUSE_LO, d);
            wr(`ADDR_TX_PAUSE_HI, e);
            wr(`ADDR_RX_PAUSE_LO, ~d);
            repeat (2) @(posedge sys_clk);
            chk("tx first byte", 32'(d[7:0]), 32'(txv[39:32]));
            chk("tx pause hi", e, 32'(txv[79:64]));
            chk("rx pause lo", ~d, rxv[63:32]);
        end
        for (int i = 0; i < 12; i++) begin
            d = (i < 4) ? corner[i] : $urandom & `CFG_WRITE_MASK;
            e = d & 32'hFFFFFFDF;
            wr(`ADDR_TX_CFG, d);
            wr(`ADDR_RX_CFG, e);
            rd_reg(`ADDR_TX_CFG);
            chk("tx cfg read", tx_eff(d), rd);
            rd_reg(`ADDR_RX_CFG);
            chk("rx cfg read", e, rd);
            chk("tx vector", tx_eff(d), txv[31:0]);
            chk("rx vector", e, rxv[31:0]);
            chk("tx reset", 32'(d[0]), 32'(txResetOut));
            chk("rx reset", 32'(d[0]), 32'(rxResetOut));
        end
        wr(`ADDR_TX_CFG, 32'h0);
        wr(`ADDR_RX_CFG, 32'h0);
        fork
            u_mac_side_model.tx_frame(30);
        join_none
        repeat (2) @(posedge sys_clk);
        wr(`ADDR_TX_CFG, 32'h4021);
        repeat (2) @(posedge sys_clk);
        chk("held in frame", 32'h21, txv[31:0]);
        wait (!txFrameActive);
        repeat (2) @(posedge sys_clk);
        chk("after frame", 32'h4021, txv[31:0]);
        wr(`ADDR_TX_CFG, 32'h0);
        wr(`ADDR_RX_PFC, 32'hFF01);
        repeat (2) @(posedge sys_clk);
        chk("pfc vector", 32'hFF01, 32'(rxv[95:80]));
        for (int p = 0; p < 8; p++) begin
            pf(8'(1 << p), 16'h2, 1'h1);
            chk("pfc hold", 32'(1 << p), 32'(rxPriorityHoldOutput));
            pf(8'(1 << p), 16'h0, 1'h1);
            chk("pfc cancel", 32'h0, 32'(rxPriorityHoldOutput));
        end
        pf(8'h01, 16'h1, 1'h1);
        repeat (10) @(posedge sys_clk);
        chk("pfc expiry", 32'h0, 32'(rxPriorityHoldOutput));
        pf(8'hFF, 16'h5, 1'h0);
        chk("bad frame", 32'h0, 32'(rxPriorityHoldOutput));
        wr(`ADDR_RX_PFC, 32'h1);
        pf(8'hFF, 16'h5, 1'h1);
        chk("prio disabled", 32'h0, 32'(rxPriorityHoldOutput));
        wr(`ADDR_RX_PFC, 32'h0);
        pf(8'hFF, 16'h5, 1'h1);
        for (int f = 0; f < 16; f++) begin
            {linkInterrupt, remoteFault, localFault} <= 3'(f);
            if (f == 8) wr(`ADDR_RX_CFG, 32'h400);
            repeat (3) @(posedge sys_clk);
            chk("rs select", rs_sel(4'(f)), 32'(rsTxSelect));
            rd_reg(`ADDR_STATUS);
            chk("status faults", 32'(f % 8), 32'(rd[2:0]));
        end
        give_verdict();
    end
endmodule // mac_config_vector_control_bench
`default_nettype wire

// [bench/mac_side_model.sv]
// Line-side model: frame activity and received PFC frames
`default_nettype none
module mac_side_model (
    input  wire logic         sys_clk,
    output var logic          txFrameActive,
    output var logic          rxFrameActive,
    output var logic          rxPfcValid,
    output var logic          rxPfcGood,
    output var logic [7:0]    rxPfcClassEnable,
    output var logic [127:0]  rxPfcQuanta
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        txFrameActive = 1'h0;
        rxFrameActive = 1'h0;
        rxPfcValid = 1'h0;
        rxPfcGood = 1'h0;
        rxPfcClassEnable = 8'h00;
        rxPfcQuanta = 128'h0;
    end
    task automatic tx_frame(input int n);
        @(posedge sys_clk);
        txFrameActive <= 1'h1;
        repeat (n) @(posedge sys_clk);
        txFrameActive <= 1'h0;
    endtask
    // Fields inverted once strobe drops
    task automatic pfc_frame(input logic [7:0] cls, input logic [15:0] q,
                             input logic good);
        @(posedge sys_clk);
        rxFrameActive <= 1'h1;
        repeat (7) @(posedge sys_clk);
        rxFrameActive <= 1'h0;
        rxPfcValid <= 1'h1;
        rxPfcGood <= good;
        rxPfcClassEnable <= cls;
        rxPfcQuanta <= {8{q}};
        @(posedge sys_clk);
        rxPfcValid <= 1'h0;
        rxPfcGood <= ~good;
        rxPfcClassEnable <= ~cls;
        rxPfcQuanta <= ~{8{q}};
    endtask
endmodule // mac_side_model
`default_nettype wire

// [rtl/mac_cfg_regs.vh]
// Offsets, fields, reset values and timing
//
// Summary of operation
// - TX size-limit enable selects programmed maximum
// - Deficit idle bit chooses shortened or aligned gaps
// - Deficit idle reads cleared when overridden
// - WAN bit stretches gaps to OC-192 rate
// - Gap adjust uses client delay, not in WAN
// - TX preamble preserve sends client preamble
// - TX flow control gates pause requests
// - TX jumbo bit lifts legal maximum length
// - TX in-band FCS: client supplies FCS
// - TX VLAN bit raises default maximum to 1522
// - TX enable and reset bits control transmitter
// - Enabled priority pause frames hold priority outputs
// - RX PFC enable acts and flags frames bad
// - RX pause address matched on control frames
// - First wire byte sits in low address byte
// - RX size-limit enable selects 15-bit maximum
// - Fault inhibit disables RS fault signalling
// - Control frame length check disable
// - Length/type error check disable
// - RX preamble preserve keeps received preamble
// - Changes other than reset, flow control, pause and PFC fields apply after current frame completes
// - 15-bit TX maximum used when limit enabled
// - RX enable and reset bits control receiver
// - RX flow control enable inhibits transmitter
`ifndef MAC_CFG_REGS_VH
`define MAC_CFG_REGS_VH

`define ADDR_TX_CFG       8'h00
`define ADDR_TX_PAUSE_LO  8'h04
`define ADDR_TX_PAUSE_HI  8'h08
`define ADDR_RX_CFG       8'h0C
`define ADDR_RX_PAUSE_LO  8'h10
`define ADDR_RX_PAUSE_HI  8'h14
`define ADDR_RX_PFC       8'h18
`define ADDR_STATUS       8'h1C

`define CFG_WRITE_MASK    32'h7FFF47BF
`define PFC_WRITE_MASK    32'h0000FF01
`define PAUSE_HI_MASK     32'h0000FFFF

`define BIT_RESET         0
`define BIT_ENABLE        1
`define BIT_VLAN          2
`define BIT_INBAND_FCS    3
`define BIT_JUMBO         4
`define BIT_FLOW_CTRL     5
`define BIT_PREAMBLE      7
`define BIT_GAP_ADJUST    8
`define BIT_WAN_MODE      9
`define BIT_DEFICIT_IDLE  10
`define BIT_FAULT_INHIBIT 10
`define BIT_CTRL_LEN_DIS  9
`define BIT_LENTYPE_DIS   8
`define BIT_LIMIT_ENABLE  14
`define BIT_PFC_ENABLE    80
`define BIT_PFC_PRIO0     88

`define CFG_RESET_VALUE   32'h00000000
`define PAUSE_RESET_VALUE 48'h000000000000

`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`define RS_PASS_DATA      2'h0
`define RS_SEND_REMOTE    2'h1
`define RS_SEND_IDLE      2'h2

// One pause quantum is 512 bit times at 10 Gb/s
`define QUANTUM_PS        51200
`define CLOCK_PERIOD_PS   10000
`define QUANTUM_CYCLES    ((`QUANTUM_PS + `CLOCK_PERIOD_PS - 1) / `CLOCK_PERIOD_PS)

`endif

// [rtl/mac_config_vector_control.v]
// AXI4-Lite register front end driving the MAC configuration vectors
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`default_nettype none
`include "mac_cfg_regs.vh"

module mac_config_vector_control #(
    parameter PRIORITIES = 8,
    parameter QUANTA_W   = 16
) (
    input  wire                         sys_clk,
    input  wire                         nrst,
    input  wire [7:0]                   s_axi_awaddr,
    input  wire                         s_axi_awvalid,
    output reg                          s_axi_awready,
    input  wire [31:0]                  s_axi_wdata,
    input  wire [3:0]                   s_axi_wstrb,
    input  wire                         s_axi_wvalid,
    output reg                          s_axi_wready,
    output reg  [1:0]                   s_axi_bresp,
    output reg                          s_axi_bvalid,
    input  wire                         s_axi_bready,
    input  wire [7:0]                   s_axi_araddr,
    input  wire                         s_axi_arvalid,
    output reg                          s_axi_arready,
    output reg  [31:0]                  s_axi_rdata,
    output reg  [1:0]                   s_axi_rresp,
    output reg                          s_axi_rvalid,
    input  wire                         s_axi_rready,
    input  wire                         txFrameActive,
    input  wire                         rxFrameActive,
    input  wire                         localFault,
    input  wire                         remoteFault,
    input  wire                         linkInterrupt,
    input  wire                         rxPfcValid,
    input  wire                         rxPfcGood,
    input  wire [PRIORITIES-1:0]        rxPfcClassEnable,
    input  wire [PRIORITIES*QUANTA_W-1:0] rxPfcQuanta,
    output reg  [79:0]                  mac_tx_configuration_vector,
    output reg  [95:0]                  mac_rx_configuration_vector,
    output reg  [PRIORITIES-1:0]        rxPriorityHoldOutput,
    output reg                          rxPfcMarkBad,
    output reg  [1:0]                   rsTxSelect,
    output reg                          txResetOut,
    output reg                          rxResetOut
);

    localparam integer CYC_LAST = `QUANTUM_CYCLES - 1;

    // Byte-lane merge of a write
    function [31:0] mergeBytes;
        input [31:0] oldWord;
        input [31:0] newWord;
        input [3:0]  strobe;
        input [31:0] mask;
        integer k;
        begin
            mergeBytes = oldWord;
            for (k = 0; k < 4; k = k + 1) begin
                if (strobe[k]) begin
                    mergeBytes[k*8 +: 8] = newWord[k*8 +: 8];
                end
            end
            mergeBytes = mergeBytes & mask;
        end
    endfunction

    function isMapped;
        input [7:0] addr;
        begin
            case (addr)
                `ADDR_TX_CFG, `ADDR_TX_PAUSE_LO, `ADDR_TX_PAUSE_HI,
                `ADDR_RX_CFG, `ADDR_RX_PAUSE_LO, `ADDR_RX_PAUSE_HI,
                `ADDR_RX_PFC, `ADDR_STATUS: isMapped = 1'b1;
                default: isMapped = 1'b0;
            endcase
        end
    endfunction

    // Gap-related overrides on a transmit config word
    function [31:0] effectiveTx;
        input [31:0] cfg;
        reg          gapAdj;
        begin
            effectiveTx = cfg;
            gapAdj = cfg[`BIT_GAP_ADJUST] & ~cfg[`BIT_WAN_MODE];
            effectiveTx[`BIT_GAP_ADJUST] = gapAdj;
            if ((~cfg[`BIT_WAN_MODE] & cfg[`BIT_INBAND_FCS]) | gapAdj) begin
                effectiveTx[`BIT_DEFICIT_IDLE] = 1'b0;
            end
        end
    endfunction

    reg  [1:0]  rstPipe;
    wire        rstN;

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstN = rstPipe[1];

    // Software-facing shadow copies
    reg  [31:0] txCfg;
    reg  [47:0] txPause;
    reg  [31:0] rxCfg;
    reg  [47:0] rxPause;
    reg  [15:0] rxPfc;

    reg         awHeld;
    reg  [7:0]  awAddr;
    reg         wHeld;
    reg  [31:0] wData;
    reg  [3:0]  wStrb;
    wire        doWrite;
    wire [31:0] txCfgEff;
    reg  [31:0] next_rdata;

    function [15:0] mergeLow;
        input [15:0] oldHalf;
        input [31:0] mask;
        reg   [31:0] merged;
        begin
            merged   = mergeBytes({16'h0000, oldHalf}, wData, wStrb, mask);
            mergeLow = merged[15:0];
        end
    endfunction

    assign doWrite  = awHeld & wHeld & ~s_axi_bvalid;
    assign txCfgEff = effectiveTx(txCfg);

    always @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            awHeld        <= 1'b0;
            awAddr        <= 8'h00;
            wHeld         <= 1'b0;
            wData         <= 32'h00000000;
            wStrb         <= 4'h0;
            txCfg         <= `CFG_RESET_VALUE;
            txPause       <= `PAUSE_RESET_VALUE;
            rxCfg         <= `CFG_RESET_VALUE;
            rxPause       <= `PAUSE_RESET_VALUE;
            rxPfc         <= 16'h0000;
        end else begin
            s_axi_awready <= ~awHeld & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~wHeld & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                awHeld <= 1'b1;
                awAddr <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid & s_axi_wready) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (doWrite) begin
                awHeld       <= 1'b0;
                wHeld        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= isMapped(awAddr) ? `RESP_OKAY : `RESP_SLVERR;
                // Reserved bits masked to zero
                case (awAddr)
                    `ADDR_TX_CFG: begin
                        txCfg <= mergeBytes(txCfg, wData, wStrb,
                                            `CFG_WRITE_MASK);
                    end
                    `ADDR_TX_PAUSE_LO: begin
                        txPause[31:0] <= mergeBytes(txPause[31:0], wData,
                                                    wStrb, 32'hFFFFFFFF);
                    end
                    `ADDR_TX_PAUSE_HI: begin
                        txPause[47:32] <= mergeLow(txPause[47:32],
                                                   `PAUSE_HI_MASK);
                    end
                    `ADDR_RX_CFG: begin
                        rxCfg <= mergeBytes(rxCfg, wData, wStrb,
                                            `CFG_WRITE_MASK);
                    end
                    `ADDR_RX_PAUSE_LO: begin
                        rxPause[31:0] <= mergeBytes(rxPause[31:0], wData,
                                                    wStrb, 32'hFFFFFFFF);
                    end
                    `ADDR_RX_PAUSE_HI: begin
                        rxPause[47:32] <= mergeLow(rxPause[47:32],
                                                   `PAUSE_HI_MASK);
                    end
                    `ADDR_RX_PFC: begin
                        rxPfc <= mergeLow(rxPfc, `PFC_WRITE_MASK);
                    end
                    default: ;
                endcase
            end
        end
    end

    // Read path, one word per request
    always @* begin
        case (s_axi_araddr[7:2])
            `ADDR_TX_CFG >> 2:      next_rdata = txCfgEff;
            `ADDR_TX_PAUSE_LO >> 2: next_rdata = txPause[31:0];
            `ADDR_TX_PAUSE_HI >> 2: next_rdata = {16'h0000, txPause[47:32]};
            `ADDR_RX_CFG >> 2:      next_rdata = rxCfg;
            `ADDR_RX_PAUSE_LO >> 2: next_rdata = rxPause[31:0];
            `ADDR_RX_PAUSE_HI >> 2: next_rdata = {16'h0000, rxPause[47:32]};
            `ADDR_RX_PFC >> 2:      next_rdata = {16'h0000, rxPfc};
            `ADDR_STATUS >> 2: begin
                next_rdata = {16'h0000, rxPriorityHoldOutput, 5'h00,
                              linkInterrupt, remoteFault, localFault};
            end
            default:                next_rdata = 32'h00000000;
        endcase
    end

    always @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= next_rdata;
                s_axi_rresp  <= isMapped({s_axi_araddr[7:2], 2'h0}) ?
                                `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Vectors toward the MAC core
    always @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            mac_tx_configuration_vector <= 80'h0;
            mac_rx_configuration_vector <= 96'h0;
            txResetOut                  <= 1'b1;
            rxResetOut                  <= 1'b1;
        end else begin
            // Reset and flow control fields pass at once
            mac_tx_configuration_vector[`BIT_RESET] <= txCfg[`BIT_RESET];
            mac_tx_configuration_vector[`BIT_FLOW_CTRL] <=
                txCfg[`BIT_FLOW_CTRL];
            mac_rx_configuration_vector[`BIT_RESET] <= rxCfg[`BIT_RESET];
            mac_rx_configuration_vector[`BIT_FLOW_CTRL] <=
                rxCfg[`BIT_FLOW_CTRL];
            mac_rx_configuration_vector[95:80] <= rxPfc;
            mac_rx_configuration_vector[79:32] <= rxPause;
            mac_tx_configuration_vector[79:32] <= txPause;
            txResetOut <= txCfg[`BIT_RESET];
            rxResetOut <= rxCfg[`BIT_RESET];
            if (!txFrameActive) begin
                // Remaining fields wait for the frame boundary
                mac_tx_configuration_vector[31:6] <= txCfgEff[31:6];
                mac_tx_configuration_vector[4:1]  <= txCfgEff[4:1];
            end
            if (!rxFrameActive) begin
                mac_rx_configuration_vector[31:6] <= rxCfg[31:6];
                mac_rx_configuration_vector[4:1]  <= rxCfg[4:1];
            end
        end
    end

    // Reconciliation sublayer fault response
    always @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            rsTxSelect <= `RS_PASS_DATA;
        end else if (mac_rx_configuration_vector[`BIT_FAULT_INHIBIT]) begin
            rsTxSelect <= `RS_PASS_DATA;
        end else if (localFault | linkInterrupt) begin
            rsTxSelect <= `RS_SEND_REMOTE;
        end else if (remoteFault) begin
            rsTxSelect <= `RS_SEND_IDLE;
        end else begin
            rsTxSelect <= `RS_PASS_DATA;
        end
    end

    // PFC frames flagged bad while enabled
    always @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            rxPfcMarkBad <= 1'b0;
        end else begin
            rxPfcMarkBad <= rxPfcValid &
                mac_rx_configuration_vector[`BIT_PFC_ENABLE];
        end
    end

    // Per-priority pause timers
    genvar p;
    generate
        for (p = 0; p < PRIORITIES; p = p + 1) begin : prio
            reg  [QUANTA_W-1:0] quantaLeft;
            reg  [2:0]          subCount;
            reg  [QUANTA_W-1:0] next_quantaLeft;
            reg  [2:0]          next_subCount;
            wire                load;

            assign load = rxPfcValid & rxPfcGood & rxPfcClassEnable[p] &
                mac_rx_configuration_vector[`BIT_PFC_ENABLE] &
                mac_rx_configuration_vector[`BIT_PFC_PRIO0 + p];

            always @* begin
                next_quantaLeft = quantaLeft;
                next_subCount   = subCount;
                if (load) begin
                    // Zero quanta cancels, nonzero refreshes
                    next_quantaLeft = rxPfcQuanta[p*QUANTA_W +: QUANTA_W];
                    next_subCount   = 3'h0;
                end else if (quantaLeft != {QUANTA_W{1'b0}}) begin
                    if (subCount == CYC_LAST) begin
                        next_subCount   = 3'h0;
                        next_quantaLeft = quantaLeft - 1'b1;
                    end else begin
                        next_subCount = subCount + 3'h1;
                    end
                end
            end

            always @(posedge sys_clk or negedge rstN) begin
                if (!rstN) begin
                    quantaLeft              <= {QUANTA_W{1'b0}};
                    subCount                <= 3'h0;
                    rxPriorityHoldOutput[p] <= 1'b0;
                end else begin
                    quantaLeft <= next_quantaLeft;
                    subCount   <= next_subCount;
                    rxPriorityHoldOutput[p] <=
                        next_quantaLeft != {QUANTA_W{1'b0}};
                end
            end
        end
    endgenerate

endmodule // mac_config_vector_control
`default_nettype wire
